/* File: src/tspwm_top.sv */
// Purpose: Span / PWM rate configuration, fan duty and overtemperature pin
// Assumes: Temperatures, limits and start points share one quarter-degree scale
// Notes:   Open-drain pin is pulled low only by enabled, asserted channels
// Overview of operation
// - Each span/rate register powers up holding 0xC4.
// - Three span/rate registers sit at indexes remote1_span_pwm1_rate, local_span_pwm2_rate, remote2_span_pwm3_rate.
// - Low three bits pick the paired PWM frequency, 11.0 to 88.2 Hz.
// - Enabled channel pulls the pin low when temperature exceeds limit by 0.25.
// - Pin stays low until temperature returns to limit or below.
// - Each pin assertion lasts at least one full monitoring cycle.
// - With enable clear the channel never drives the pin; pin is input.
// - Upper four bits pick the temperature span of the duty slope.
// - Behavior field picks controlling channel, fastest, full, off or manual.
// - Polarity bit inverts the PWM output level.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module tspwm_top #(
  parameter int CLK_HZ = tspwm_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Measured temperatures
  input  wire logic [9:0]  temp_remote1,
  input  wire logic [9:0]  temp_local,
  input  wire logic [9:0]  temp_remote2,
  input  wire logic        monitor_cycle_done,
  // Automatic control settings
  input  wire logic [9:0]  fan_start_temperature1,
  input  wire logic [9:0]  fan_start_temperature2,
  input  wire logic [9:0]  fan_start_temperature3,
  input  wire logic [7:0]  min_duty1,
  input  wire logic [7:0]  min_duty2,
  input  wire logic [7:0]  min_duty3,
  // Overtemperature pin, active low, open drain
  input  wire logic        overtemp_pin_n_i,
  output logic             overtemp_pin_n_o,
  output logic             overtemp_pin_n_oe,
  // Fan outputs and interrupt
  output logic             pwm1,
  output logic             pwm2,
  output logic             pwm3,
  output logic             irq
);
  typedef struct packed {
    logic [2:0][7:0] span_rate;
    logic [2:0][7:0] behav;
    logic [2:0][7:0] duty;
    logic [2:0][9:0] limit;
    logic [2:0]      ot_act;
    logic [2:0][1:0] ot_hold;
    logic [3:0]      int_stat;
    logic [3:0]      int_en;
    logic            irq;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            pin_oe;
    logic [2:0]      pin_sync;
    logic            pin_lvl;
    logic            seen;
  } tspwm_main_t;

  // Power-on values; pin filter starts at the pulled-up idle level, no false edge
  localparam tspwm_main_t RST_VAL = '{
    span_rate: {3{tspwm_pkg::SPAN_RATE_RST}},
    behav:     {3{tspwm_pkg::BEHAV_RST}},
    limit:     {3{tspwm_pkg::LIMIT_RST}},
    pin_sync:  3'h7,
    pin_lvl:   1'b1,
    default:   '0
  };

  tspwm_main_t      st_ff;
  tspwm_main_t      nxt_st;
  logic [2:0][9:0]  temp;
  logic [2:0][9:0]  tstart;
  logic [2:0][7:0]  dmin;
  logic [2:0][7:0]  auto_duty;
  logic [2:0][7:0]  out_duty;
  logic [2:0]       ot_en;
  logic [2:0]       ot_trip;
  logic [2:0]       ot_clear_ok;
  logic [3:0]       int_evt;
  logic [9:0]       idx;
  logic             setup;
  logic             wr_en;
  logic             hit;
  logic [7:0]       span_room;
  logic [9:0]       diff;
  logic [33:0]      prod;
  logic [7:0]       scaled;

  // Gather per-channel inputs into arrays
  assign temp   = {temp_remote2, temp_local, temp_remote1};
  assign tstart = {fan_start_temperature3, fan_start_temperature2, fan_start_temperature1};
  assign dmin   = {min_duty3, min_duty2, min_duty1};
  assign idx    = paddr[11:2];
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && st_ff.pready && pwrite && !st_ff.pslverr;

  // Address decode for the setup cycle
  always_comb begin
    hit = 1'b0;
    for (int c = 0; c < 3; c++) begin
      if (idx == tspwm_pkg::IDX_SPAN_R1 + 10'(c)) hit = 1'b1;
      if (idx == tspwm_pkg::IDX_BEHAV0 + 10'(c))  hit = 1'b1;
      if (idx == tspwm_pkg::IDX_DUTY0 + 10'(c))   hit = 1'b1;
      if (idx == tspwm_pkg::IDX_LIMIT0 + 10'(c))  hit = 1'b1;
    end
    if (idx inside {tspwm_pkg::IDX_INT_STAT, tspwm_pkg::IDX_INT_EN,
                    tspwm_pkg::IDX_INT_CLR, tspwm_pkg::IDX_OT_STATE}) hit = 1'b1;
  end

  // Automatic duty per temperature channel
  always_comb begin
    auto_duty = '0;
    span_room = '0;
    diff      = '0;
    prod      = '0;
    scaled    = '0;
    for (int c = 0; c < 3; c++) begin
      span_room = tspwm_pkg::DUTY_FULL - dmin[c];
      if (temp[c] <= tstart[c]) begin
        auto_duty[c] = dmin[c];
      end else begin
        diff = temp[c] - tstart[c];
        prod = 34'(diff) * 34'(span_room)
             * 34'(tspwm_pkg::span_recip(st_ff.span_rate[c][tspwm_pkg::SPAN_LSB +: 4]));
        scaled = (prod[33:16] >= 18'(span_room)) ? span_room : prod[23:16];
        auto_duty[c] = dmin[c] + scaled;
      end
    end
  end

  // Behavior select per PWM output
  always_comb begin
    out_duty = '0;
    for (int c = 0; c < 3; c++) begin
      unique case (st_ff.behav[c][tspwm_pkg::FAN_CONTROL_BEHAVIOR_LSB +: tspwm_pkg::FAN_CONTROL_BEHAVIOR_W])
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_R1:     out_duty[c] = auto_duty[0];
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_LOC:    out_duty[c] = auto_duty[1];
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_R2:     out_duty[c] = auto_duty[2];
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_FULL:   out_duty[c] = tspwm_pkg::DUTY_FULL;
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_OFF:    out_duty[c] = 8'h00;
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_MAXLR2: out_duty[c] = (auto_duty[1] > auto_duty[2]) ?
                                              auto_duty[1] : auto_duty[2];
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_MAXALL: begin
          out_duty[c] = (auto_duty[1] > auto_duty[2]) ? auto_duty[1] : auto_duty[2];
          if (auto_duty[0] > out_duty[c]) out_duty[c] = auto_duty[0];
        end
        tspwm_pkg::FAN_CONTROL_BEHAVIOR_MANUAL: out_duty[c] = st_ff.duty[c];
      endcase
    end
  end

  // Overtemperature compare per channel
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      ot_en[c]       = st_ff.span_rate[c][tspwm_pkg::OTEN_BIT];
      ot_trip[c]     = temp[c] > st_ff.limit[c];
      ot_clear_ok[c] = (temp[c] <= st_ff.limit[c])
                    && (st_ff.ot_hold[c] >= tspwm_pkg::OT_HOLD_PULSES);
    end
  end

  // Next state: registers, overtemperature, interrupts, APB answer
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.seen = 1'b1;
    int_evt     = '0;
    // Overtemperature state per channel
    for (int c = 0; c < 3; c++) begin
      if (!st_ff.ot_act[c]) begin
        if (ot_trip[c]) begin
          nxt_st.ot_act[c]  = 1'b1;
          nxt_st.ot_hold[c] = 2'h0;
          int_evt[c]        = 1'b1;
        end
      end else begin
        // Two pulses, since the first may close a cycle already under way
        if (monitor_cycle_done && st_ff.ot_hold[c] < tspwm_pkg::OT_HOLD_PULSES)
          nxt_st.ot_hold[c] = st_ff.ot_hold[c] + 2'h1;
        if (ot_clear_ok[c]) nxt_st.ot_act[c] = 1'b0;
      end
    end
    // Pin drive: any enabled asserted channel
    nxt_st.pin_oe = |(ot_en & st_ff.ot_act);
    // Pin input sampling, change once stages two and three agree
    nxt_st.pin_sync = {st_ff.pin_sync[1:0], overtemp_pin_n_i};
    if (st_ff.pin_sync[1] == st_ff.pin_sync[2]) begin
      nxt_st.pin_lvl = st_ff.pin_sync[2];
      if (st_ff.pin_lvl && !st_ff.pin_sync[2]) int_evt[tspwm_pkg::INT_PIN_BIT] = 1'b1;
    end
    // APB answer, one wait-free access phase
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup && !hit;
    nxt_st.prdata  = '0;
    if (setup && !pwrite) begin
      for (int c = 0; c < 3; c++) begin
        if (idx == tspwm_pkg::IDX_SPAN_R1 + 10'(c)) nxt_st.prdata = 32'(st_ff.span_rate[c]);
        if (idx == tspwm_pkg::IDX_BEHAV0 + 10'(c))  nxt_st.prdata = 32'(st_ff.behav[c]);
        if (idx == tspwm_pkg::IDX_DUTY0 + 10'(c))   nxt_st.prdata = 32'(st_ff.duty[c]);
        if (idx == tspwm_pkg::IDX_LIMIT0 + 10'(c))  nxt_st.prdata = 32'(st_ff.limit[c]);
      end
      if (idx == tspwm_pkg::IDX_INT_STAT) nxt_st.prdata = 32'(st_ff.int_stat);
      if (idx == tspwm_pkg::IDX_INT_EN)   nxt_st.prdata = 32'(st_ff.int_en);
      if (idx == tspwm_pkg::IDX_OT_STATE) nxt_st.prdata = 32'({st_ff.pin_lvl, st_ff.pin_oe,
                                                              st_ff.ot_act});
    end
    // Register writes at the access edge
    if (wr_en) begin
      for (int c = 0; c < 3; c++) begin
        if (idx == tspwm_pkg::IDX_SPAN_R1 + 10'(c)) nxt_st.span_rate[c] = pwdata[7:0];
        if (idx == tspwm_pkg::IDX_BEHAV0 + 10'(c))  nxt_st.behav[c] = pwdata[7:0];
        if (idx == tspwm_pkg::IDX_DUTY0 + 10'(c))   nxt_st.duty[c] = pwdata[7:0];
        if (idx == tspwm_pkg::IDX_LIMIT0 + 10'(c))  nxt_st.limit[c] = pwdata[9:0];
      end
      if (idx == tspwm_pkg::IDX_INT_EN)  nxt_st.int_en = pwdata[3:0];
      if (idx == tspwm_pkg::IDX_INT_CLR) nxt_st.int_stat = st_ff.int_stat & ~pwdata[3:0];
    end
    // Events set sticky bits, set wins over clear
    nxt_st.int_stat = nxt_st.int_stat | int_evt;
    nxt_st.irq      = |(nxt_st.int_stat & nxt_st.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= RST_VAL;
    else          st_ff <= nxt_st;
  end

  // PWM generators, one per fan output
  tspwm_pwm #(.CLK_HZ(CLK_HZ)) u_pwm1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .rate_sel (st_ff.span_rate[0][tspwm_pkg::RATE_LSB +: tspwm_pkg::RATE_W]),
    .duty     (out_duty[0]),
    .invert   (st_ff.behav[0][tspwm_pkg::INV_BIT]),
    .pwm_out  (pwm1)
  );
  tspwm_pwm #(.CLK_HZ(CLK_HZ)) u_pwm2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .rate_sel (st_ff.span_rate[1][tspwm_pkg::RATE_LSB +: tspwm_pkg::RATE_W]),
    .duty     (out_duty[1]),
    .invert   (st_ff.behav[1][tspwm_pkg::INV_BIT]),
    .pwm_out  (pwm2)
  );
  tspwm_pwm #(.CLK_HZ(CLK_HZ)) u_pwm3 (
    .pclk     (pclk),
    .presetn  (presetn),
    .rate_sel (st_ff.span_rate[2][tspwm_pkg::RATE_LSB +: tspwm_pkg::RATE_W]),
    .duty     (out_duty[2]),
    .invert   (st_ff.behav[2][tspwm_pkg::INV_BIT]),
    .pwm_out  (pwm3)
  );

  // Outputs straight from flip-flops, except the pin data tied low
  assign prdata            = st_ff.prdata;
  assign pready            = st_ff.pready;
  assign pslverr           = st_ff.pslverr;
  assign irq               = st_ff.irq;
  assign overtemp_pin_n_oe = st_ff.pin_oe;
  assign overtemp_pin_n_o  = 1'b0; // Open drain, only ever pulls low

  // Checks on registers, overtemperature state, pin drive and fan duty
  property p_reset_value;
    @(posedge pclk) disable iff (!presetn)
      !st_ff.seen |-> (st_ff.span_rate == {3{tspwm_pkg::SPAN_RATE_RST}});
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Span reset value wrong");

  property p_span_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == tspwm_pkg::IDX_SPAN_LOC) |=> (st_ff.span_rate[1] == $past(pwdata[7:0]));
  endproperty
  a_span_write: assert property (p_span_write) else $error("Span write lost");

  property p_trip;
    @(posedge pclk) disable iff (!presetn)
      (!st_ff.ot_act[0] && temp[0] > st_ff.limit[0]) |=> st_ff.ot_act[0];
  endproperty
  a_trip: assert property (p_trip) else $error("Overtemp not taken");

  property p_stay;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.ot_act[1] && temp[1] > st_ff.limit[1]) |=> st_ff.ot_act[1];
  endproperty
  a_stay: assert property (p_stay) else $error("Overtemp released early");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.ot_act[2] && st_ff.ot_hold[2] < tspwm_pkg::OT_HOLD_PULSES) |=> st_ff.ot_act[2];
  endproperty
  a_hold: assert property (p_hold) else $error("Overtemp shorter than cycle");

  property p_no_drive;
    @(posedge pclk) disable iff (!presetn)
      st_ff.pin_oe |-> $past(|(ot_en & st_ff.ot_act));
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("Pin driven while disabled");

  property p_full_speed;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.behav[0][7:5] == tspwm_pkg::FAN_CONTROL_BEHAVIOR_FULL) |-> (out_duty[0] == tspwm_pkg::DUTY_FULL);
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("Full speed not chosen");

  property p_auto_min;
    @(posedge pclk) disable iff (!presetn)
      (temp[1] <= tstart[1]) |-> (auto_duty[1] == dmin[1]);
  endproperty
  a_auto_min: assert property (p_auto_min) else $error("Duty below start not minimum");

  property p_pin_or;
    @(posedge pclk) disable iff (!presetn)
      ##1 (st_ff.pin_oe == $past(|(ot_en & st_ff.ot_act)));
  endproperty
  a_pin_or: assert property (p_pin_or) else $error("Pin drive not OR of channels");

  property p_release_hold;
    @(posedge pclk) disable iff (!presetn)
      $fell(st_ff.ot_act[0]) |-> ($past(st_ff.ot_hold[0]) >= tspwm_pkg::OT_HOLD_PULSES);
  endproperty
  a_release_hold: assert property (p_release_hold) else $error("Hold cut short");

  property p_trip_flag;
    @(posedge pclk) disable iff (!presetn)
      $rose(st_ff.ot_act[0]) |-> st_ff.int_stat[0];
  endproperty
  a_trip_flag: assert property (p_trip_flag) else $error("Overtemp not flagged");

  property p_auto_floor;
    @(posedge pclk) disable iff (!presetn)
      (temp[2] > tstart[2]) |-> (auto_duty[2] >= dmin[2]);
  endproperty
  a_auto_floor: assert property (p_auto_floor) else $error("Auto duty under minimum");
endmodule : tspwm_top

/* File: src/tspwm_pkg.sv */
// Purpose: Shared constants for the temperature span / PWM rate block
// Assumes: APB data 32 bits, byte address = 4 x register index
// Notes:   Temperatures are unsigned quarter-degree codes
package tspwm_pkg;
  // Register indexes, byte address is four times the index
  localparam logic [9:0] IDX_SPAN_R1   = 10'h05F;
  localparam logic [9:0] IDX_SPAN_LOC  = 10'h060;
  localparam logic [9:0] IDX_SPAN_R2   = 10'h061;
  localparam logic [9:0] IDX_DUTY0     = 10'h030;
  localparam logic [9:0] IDX_BEHAV0    = 10'h068;
  localparam logic [9:0] IDX_LIMIT0    = 10'h06B;
  localparam logic [9:0] IDX_INT_STAT  = 10'h070;
  localparam logic [9:0] IDX_INT_EN    = 10'h071;
  localparam logic [9:0] IDX_INT_CLR   = 10'h072;
  localparam logic [9:0] IDX_OT_STATE  = 10'h073;
  // Reset values
  localparam logic [7:0] SPAN_RATE_RST = 8'hC4;
  localparam logic [7:0] BEHAV_RST     = 8'h60;
  localparam logic [9:0] LIMIT_RST     = 10'h190;
  // Span/rate field positions
  localparam int RATE_LSB  = 0;
  localparam int RATE_W    = 3;
  localparam int OTEN_BIT  = 3;
  localparam int SPAN_LSB  = 4;
  localparam int SPAN_W    = 4;
  // Behavior register field positions
  localparam int INV_BIT   = 4;
  localparam int FAN_CONTROL_BEHAVIOR_LSB  = 5;
  localparam int FAN_CONTROL_BEHAVIOR_W    = 3;
  // Behavior codes
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_R1     = 3'h0;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_LOC    = 3'h1;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_R2     = 3'h2;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_FULL   = 3'h3;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_OFF    = 3'h4;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_MAXLR2 = 3'h5;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_MAXALL = 3'h6;
  localparam logic [2:0] FAN_CONTROL_BEHAVIOR_MANUAL = 3'h7;
  // Interrupt status bit positions
  localparam int INT_PIN_BIT = 3;
  // Timing
  localparam int CLK_HZ    = 25_000_000;
  localparam int PWM_STEPS = 256;
  localparam int PWM_RATE_SELECT_DHZ [8] = '{110, 147, 221, 294, 353, 441, 588, 882};
  localparam logic [1:0] OT_HOLD_PULSES = 2'h2;
  localparam logic [7:0] DUTY_FULL = 8'hFF;

  // 65536 divided by the span in quarter degrees
  function automatic logic [15:0] span_recip(input logic [3:0] code);
    logic [15:0] r;
    r = 16'h2000;
    case (code)
      4'h0: r = 16'h2000;
      4'h1: r = 16'h199A;
      4'h2: r = 16'h1333;
      4'h3: r = 16'h1000;
      4'h4: r = 16'h0CCD;
      4'h5: r = 16'h099A;
      4'h6: r = 16'h0800;
      4'h7: r = 16'h0666;
      4'h8: r = 16'h04CD;
      4'h9: r = 16'h0400;
      4'hA: r = 16'h0333;
      4'hB: r = 16'h0266;
      4'hC: r = 16'h0200;
      4'hD: r = 16'h019A;
      4'hE: r = 16'h0133;
      default: r = 16'h00CD;
    endcase
    return r;
  endfunction : span_recip
endpackage : tspwm_pkg

/* File: src/tspwm_pwm.sv */
// Purpose: One PWM output with 256 duty steps and selectable rate
// Assumes: Duty 0xFF means always on
// Notes:   Duty is taken at the start of each period to avoid runt pulses
`timescale 1ns/1ps
module tspwm_pwm #(
  parameter int CLK_HZ = tspwm_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] duty,
  input  wire logic       invert,
  // Output
  output logic            pwm_out
);
  typedef struct packed {
    logic [15:0] pre;
    logic [7:0]  phase;
    logic [7:0]  duty;
    logic        out;
  } tspwm_pwm_t;

  function automatic logic [15:0] step_of(input int i);
    int s;
    s = (CLK_HZ * 10) / (tspwm_pkg::PWM_RATE_SELECT_DHZ[i] * tspwm_pkg::PWM_STEPS);
    if (s < 1) s = 1;
    return 16'(s);
  endfunction : step_of

  localparam logic [15:0] STEP_TBL [8] = '{step_of(0), step_of(1), step_of(2), step_of(3),
                                           step_of(4), step_of(5), step_of(6), step_of(7)};

  tspwm_pwm_t st_ff;
  tspwm_pwm_t nxt_st;
  logic       on;

  // Prescaler, phase counter and output level
  always_comb begin
    nxt_st = st_ff;
    on     = (st_ff.phase < st_ff.duty) || (st_ff.duty == tspwm_pkg::DUTY_FULL);
    if (st_ff.pre >= STEP_TBL[rate_sel] - 16'h0001) begin
      nxt_st.pre   = 16'h0000;
      nxt_st.phase = st_ff.phase + 8'h01;
      if (st_ff.phase == 8'hFF) nxt_st.duty = duty;
    end else begin
      nxt_st.pre = st_ff.pre + 16'h0001;
    end
    nxt_st.out = on ^ invert;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= '0;
    else          st_ff <= nxt_st;
  end

  assign pwm_out = st_ff.out;

  property p_rate_step;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.pre == 16'h0000 && $past(st_ff.pre) != 16'h0000 && $stable(rate_sel)
       && $past(rate_sel, 2) == rate_sel) // Skip the cut period after a rate change
      |-> ($past(st_ff.pre) == STEP_TBL[rate_sel] - 16'h0001);
  endproperty
  a_rate_step: assert property (p_rate_step) else $error("PWM step length wrong");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.duty == tspwm_pkg::DUTY_FULL) |=> (st_ff.out == ~$past(invert));
  endproperty
  a_polarity: assert property (p_polarity) else $error("Full duty level wrong");
endmodule : tspwm_pwm

/* File: verif/tspwm_far_side.sv */
// Purpose: Far-side model, fans and throttling logic on the shared pin
// Assumes: Pin has a pull-up; the throttling side may pull it low too
// Notes:   Measures the pwm1 period in clocks between rising edges
`timescale 1ns/1ps
module tspwm_far_side (
  // Clock
  input  wire logic        pclk,
  // Device side
  input  wire logic        pwm1,
  input  wire logic        pin_n_o,
  input  wire logic        pin_n_oe,
  // Bench command and observations
  input  wire logic        throttle_pull,
  output logic             pin_n,
  output logic [31:0]      period_ff
);
  logic        prev_ff;
  logic [31:0] cnt_ff;

  // Wired-AND of both pullers, pull-up level otherwise
  assign pin_n = !((pin_n_oe && !pin_n_o) || throttle_pull);

  // Period meter, latched at each rising edge of pwm1
  always_ff @(posedge pclk) begin
    prev_ff <= pwm1;
    if (pwm1 && !prev_ff) begin
      period_ff <= cnt_ff;
      cnt_ff    <= 32'h1;
    end else begin
      cnt_ff    <= cnt_ff + 32'h1;
    end
  end
endmodule : tspwm_far_side

/* File: verif/tb_temp_span_pwm_rate_config.sv */
// Purpose: Self-checking bench for span/rate registers, PWM and overtemp pin
// Assumes: APB answers within the timeout; CLK_HZ scaled down for short periods
// Notes:   PWM periods are measured by the far-side model
`timescale 1ns/1ps
module tb_temp_span_pwm_rate_config;
  localparam int CLK   = 38400;
  localparam int LIMIT = 80000;
  localparam logic [2:0] MODE [10] = '{3'h3, 3'h3, 3'h4, 3'h0, 3'h1, 3'h2, 3'h5, 3'h6,
                                       3'h7, 3'h7};
  localparam logic [9:0] INVB = 10'b0000000010;
  localparam logic [7:0] DU   [10] = '{8: 8'hFF, default: 8'h00};
  localparam logic [9:0] FL   = 10'b0110001001;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, period, rd, cnt;
  logic [31:0] comparisons, err_total, cycles;
  logic [9:0]  t1, t2, t3, tstart;
  logic [7:0]  mdut;
  logic        mon, pin_n, pin_oe, pin_o, pull, pwm1, pwm2, pwm3, irq;

  // Device under test
  tspwm_top #(.CLK_HZ(CLK)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_remote1(t1), .temp_local(t2), .temp_remote2(t3), .monitor_cycle_done(mon),
    .fan_start_temperature1(tstart), .fan_start_temperature2(tstart),
    .fan_start_temperature3(tstart), .min_duty1(mdut), .min_duty2(mdut),
    .min_duty3(mdut), .overtemp_pin_n_i(pin_n), .overtemp_pin_n_o(pin_o),
    .overtemp_pin_n_oe(pin_oe), .pwm1(pwm1), .pwm2(pwm2), .pwm3(pwm3), .irq(irq));

  // Fans and throttling side
  tspwm_far_side far_u (
    .pclk(pclk), .pwm1(pwm1), .pin_n_o(pin_o), .pin_n_oe(pin_oe),
    .throttle_pull(pull), .pin_n(pin_n), .period_ff(period));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Monitoring cycle end pulses
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      mon <= 1'b1;
      @(posedge pclk);
      mon <= 1'b0;
    end
  endtask : pulse

  // Set pwm1 behavior and duty, then count high cycles over 1024 clocks
  task automatic level(input logic [7:0] bh, input logic [7:0] du);
    wr(tspwm_pkg::IDX_BEHAV0, {24'h0, bh});
    wr(tspwm_pkg::IDX_DUTY0, {24'h0, du});
    tick(1100);
    cnt = 32'h0;
    repeat (1024) begin
      @(posedge pclk);
      cnt = cnt + {31'h0, pwm1};
    end
  endtask : level

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 32'h1;
    if (cycles == LIMIT) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  // Main sequence
  initial begin
    comparisons = 32'h0;
    err_total = 32'h0;
    cycles = 32'h0;
    {presetn, psel, penable, pwrite, mon, pull} = 6'h00;
    {paddr, pwdata} = 44'h0;
    {t1, t2, t3} = 30'h0;
    tstart = 10'h100;
    mdut = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) rdchk(10'(tspwm_pkg::IDX_SPAN_R1 + i), 32'hC4);
    for (int i = 0; i < 3; i++) wr(10'(tspwm_pkg::IDX_SPAN_R1 + i), 32'hFFFFFFA1 + i);
    for (int i = 0; i < 3; i++) rdchk(10'(tspwm_pkg::IDX_SPAN_R1 + i), 32'hA1 + i);
    apb(1'b0, 10'h3FF, 32'h0);
    check({31'h0, sl}, 32'h1);
    wr(tspwm_pkg::IDX_SPAN_R1, 32'hC4);
    // Behavior modes with remote 1 hot, others cold
    @(posedge pclk);
    t1 <= 10'h200;
    for (int i = 0; i < 10; i++) begin
      level({MODE[i], INVB[i], 4'h0}, DU[i]);
      check(cnt, FL[i] ? 32'd1024 : 32'd0);
    end
    // Narrow and wide span at start plus two degrees
    @(posedge pclk);
    t1 <= 10'h108;
    wr(tspwm_pkg::IDX_SPAN_R1, 32'h04);
    level({tspwm_pkg::FAN_CONTROL_BEHAVIOR_R1, 5'h00}, 8'h00);
    check(cnt, 32'd1024);
    wr(tspwm_pkg::IDX_SPAN_R1, 32'hF4);
    level({tspwm_pkg::FAN_CONTROL_BEHAVIOR_R1, 5'h00}, 8'h00);
    check({31'h0, cnt > 0 && cnt < 1024}, 32'h1);
    // Below start temperature the minimum duty rules
    @(posedge pclk);
    t1   <= 10'h0F0;
    mdut <= 8'hFF;
    level({tspwm_pkg::FAN_CONTROL_BEHAVIOR_R1, 5'h00}, 8'h00);
    check(cnt, 32'd1024);
    mdut <= 8'h00;
    // Every rate code at half duty
    wr(tspwm_pkg::IDX_BEHAV0, {24'h0, tspwm_pkg::FAN_CONTROL_BEHAVIOR_MANUAL, 5'h00});
    wr(tspwm_pkg::IDX_DUTY0, 32'h80);
    for (int r = 0; r < 8; r++) begin
      wr(tspwm_pkg::IDX_SPAN_R1, {28'hC, 1'b0, r[2:0]});
      repeat (3) @(posedge pwm1);
      tick(2);
      check(period, 256 * ((CLK * 10) / (tspwm_pkg::PWM_RATE_SELECT_DHZ[r] * 256)));
    end
    // Overtemperature on channel 1, limit at its reset value
    @(posedge pclk);
    t1 <= 10'h000;
    pulse(3);
    wr(tspwm_pkg::IDX_INT_CLR, 32'h0F);
    rdchk(tspwm_pkg::IDX_INT_STAT, 32'h0);
    wr(tspwm_pkg::IDX_INT_EN, 32'h0F);
    wr(tspwm_pkg::IDX_SPAN_R1, 32'hCC);
    @(posedge pclk);
    t1 <= 10'h190;
    tick(4);
    #1 check(32'(pin_oe), 32'h0);
    @(posedge pclk);
    t1 <= 10'h191;
    tick(2);
    #1 check({30'h0, pin_oe, irq}, 32'h3);
    pulse(1);
    @(posedge pclk);
    t1 <= 10'h190;
    tick(4);
    #1 check(32'(pin_oe), 32'h1);
    pulse(1);
    tick(3);
    #1 check(32'(pin_oe), 32'h0);
    @(posedge pclk);
    t1 <= 10'h191;
    pulse(3);
    #1 check(32'(pin_oe), 32'h1);
    @(posedge pclk);
    t1 <= 10'h190;
    tick(3);
    #1 check(32'(pin_oe), 32'h0);
    // Channel 2 hot but not enabled, then enabled
    @(posedge pclk);
    t2 <= 10'h1FF;
    tick(4);
    #1 check(32'(pin_oe), 32'h0);
    rdchk(tspwm_pkg::IDX_INT_STAT, 32'h0B);
    wr(tspwm_pkg::IDX_SPAN_LOC, 32'hCC);
    tick(3);
    #1 check(32'(pin_oe), 32'h1);
    @(posedge pclk);
    t2 <= 10'h000;
    pulse(2);
    tick(3);
    #1 check(32'(pin_oe), 32'h0);
    // Pin pulled by the throttling side, masked and cleared
    wr(tspwm_pkg::IDX_INT_CLR, 32'h0F);
    rdchk(tspwm_pkg::IDX_INT_STAT, 32'h0);
    @(posedge pclk);
    pull <= 1'b1;
    tick(8);
    pull <= 1'b0;
    rdchk(tspwm_pkg::IDX_INT_STAT, 32'h08);
    #1 check(32'(irq), 32'h1);
    wr(tspwm_pkg::IDX_INT_EN, 32'h0);
    tick(3);
    #1 check(32'(irq), 32'h0);
    rdchk(tspwm_pkg::IDX_INT_STAT, 32'h08);
    wr(tspwm_pkg::IDX_INT_CLR, 32'h08);
    rdchk(tspwm_pkg::IDX_INT_STAT, 32'h0);
    // Untouched outputs two and three still run full speed
    #1 check({30'h0, pwm3, pwm2}, 32'h3);
    test_done();
  end
endmodule : tb_temp_span_pwm_rate_config
